/* sound_generator.sv */
/*
 * Buzzer and melody sound generator: registers, operating clock, playback and pins.
 * Assumes a plain register port with reads answered one cycle later and synchronous inputs.
 */
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module sound_generator
    import sound_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic [2:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_wr_full_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o,
    input  wire logic        debug_mode_i,
    input  wire logic        internal_osc_tick_i,
    input  wire logic        low_speed_osc_tick_i,
    input  wire logic        high_speed_osc_tick_i,
    input  wire logic        external_clock_tick_i,
    output logic             buzz_o,
    output logic             buzz_n_o,
    output logic             irq_o
);
    //--------------------------------------------------------------------------
    // Registers and decode
    //--------------------------------------------------------------------------
    logic [15:0]    clock_ctl_ff;
    logic [15:0]    select_ff;
    logic           enable_ff;
    logic           stop_ff;
    logic [15:0]    data_ff;
    logic           empty_ff;
    logic           done_ff;
    logic           busy_ff;
    logic [1:0]     mask_ff;
    logic           tick_hold_ff;
    play_state_type state_ff;
    logic [15:0]    cur_ff;
    logic [12:0]    step_cnt_ff;
    logic [5:0]     unit_cnt_ff;

    logic           wr_clock;
    logic           wr_select;
    logic           wr_run;
    logic           wr_flags;
    logic           wr_mask;
    logic           data_wr;
    logic [1:0]     src_sel;
    logic [2:0]     div_sel;
    logic [1:0]     mode;
    logic [3:0]     stim;
    logic           clock_run;
    logic           src_tick;
    logic           undiv_only;
    logic           div_tick;
    logic           eff_tick;
    logic           pend;
    logic           note_end;
    logic           stop_now;
    logic           do_load;
    logic           do_end;
    logic [12:0]    step_last;
    logic [5:0]     unit_last;
    logic           melody;
    logic           wave;
    logic           gap;
    logic           sounding;
    logic           nxt_buzz;

    // Strobe decode; a byte-wide data write is dropped
    assign wr_clock  = reg_wr_i && (reg_addr_i == ADR_CLOCK) && !enable_ff; // see R04
    assign wr_select = reg_wr_i && (reg_addr_i == ADR_SELECT);
    assign wr_run    = reg_wr_i && (reg_addr_i == ADR_RUN);
    assign wr_flags  = reg_wr_i && (reg_addr_i == ADR_FLAGS);
    assign wr_mask   = reg_wr_i && (reg_addr_i == ADR_MASK);
    assign data_wr   = reg_wr_i && (reg_addr_i == ADR_DATA) && reg_wr_full_i; // see R18

    assign src_sel = clock_ctl_ff[SRC_LSB +: 2];
    assign div_sel = clock_ctl_ff[DIV_LSB +: 3];
    assign mode    = select_ff[MODE_LSB +: 2];
    assign stim    = select_ff[STIM_LSB +: 4];
    assign melody  = (mode == MODE_MELODY);

    // Clock control register, locked while enabled
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            clock_ctl_ff <= 16'h0000;
        end else if (wr_clock) begin
            clock_ctl_ff <= reg_wdata_i & CLOCK_MASK; // see R19
        end
    end

    // Mode select register: tempo, drive scheme, output mode
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            select_ff <= 16'h0000;
        end else if (wr_select) begin
            select_ff <= reg_wdata_i & SELECT_MASK; // see R09
        end
    end

    // Run control: enable level and stop request
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            enable_ff <= 1'b0;
            stop_ff   <= 1'b0;
        end else begin
            if (wr_run) begin
                enable_ff <= reg_wdata_i[EN_BIT];
            end
            if (wr_run && reg_wdata_i[STOP_BIT]) begin
                stop_ff <= 1'b1; // see R10
            end else if (stop_now) begin
                stop_ff <= 1'b0; // see R10
            end
        end
    end

    // Sound buffer
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            data_ff <= DATA_RST;
        end else if (data_wr) begin
            data_ff <= reg_wdata_i; // see R13
        end
    end

    // Interrupt mask
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            mask_ff <= 2'h0;
        end else if (wr_mask) begin
            mask_ff <= reg_wdata_i[1:0];
        end
    end

    //--------------------------------------------------------------------------
    // Operating clock
    //--------------------------------------------------------------------------

    // Enable and debug state gate the clock
    assign clock_run = enable_ff && (!debug_mode_i || clock_ctl_ff[DEBUG_CLOCK_RUN_BIT]); // see R01 see R12

    // Source selection
    always_comb begin
        undiv_only = 1'b0;
        unique case (src_sel)
            SRC_INTERNAL:   src_tick = internal_osc_tick_i;
            SRC_LOW_SPEED: begin
                src_tick   = low_speed_osc_tick_i;
                undiv_only = 1'b1;
            end
            SRC_HIGH_SPEED: src_tick = high_speed_osc_tick_i;
            SRC_EXTERNAL: begin
                src_tick   = external_clock_tick_i;
                undiv_only = 1'b1;
            end
        endcase
    end

    op_clock_div u_div (
        .clk_sys_i    (clk_sys_i),
        .resetn_i     (resetn_i),
        .src_tick_i   (src_tick && clock_run), // see R03
        .div_code_i   (div_sel),
        .undiv_only_i (undiv_only),
        .op_tick_o    (div_tick)
    );

    // A tick meeting a data write waits one cycle
    assign eff_tick = (div_tick && !data_wr) || tick_hold_ff;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            tick_hold_ff <= 1'b0;
        end else begin
            tick_hold_ff <= div_tick && data_wr;
        end
    end

    //--------------------------------------------------------------------------
    // Playback sequencing
    //--------------------------------------------------------------------------

    // Step is 1/64 s times tempo code plus one
    assign step_last = 13'((13'(stim) + 13'h0001) * STEP_TICKS - 13'h0001); // see R05 see R06
    assign unit_last = melody ? cur_ff[LEN_LSB +: 6] : 6'h00;
    assign note_end  = (step_cnt_ff == step_last) && (unit_cnt_ff == unit_last) && (mode != MODE_NORMAL);
    assign pend      = !empty_ff;
    assign stop_now  = eff_tick && stop_ff;

    // Load on trigger; one-shot ends at note end, melody when nothing follows
    always_comb begin
        do_load = 1'b0;
        do_end  = 1'b0;
        if (eff_tick && !stop_ff) begin
            if (state_ff == ST_IDLE) begin
                do_load = pend; // see R13
            end else if (mode == MODE_NORMAL || mode == 2'h3) begin
                do_load = pend; // see R11
            end else if (note_end) begin
                do_load = melody && pend; // see R15
                do_end  = !(melody && pend); // see R16
            end
        end else if (stop_now) begin
            do_end = (state_ff == ST_PLAY); // see R11
        end
    end

    // Current note, state and duration counters
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            state_ff    <= ST_IDLE;
            busy_ff     <= 1'b0;
            cur_ff      <= DATA_RST;
            step_cnt_ff <= 13'h0000;
            unit_cnt_ff <= 6'h00;
        end else if (do_load) begin
            state_ff    <= ST_PLAY;
            busy_ff     <= 1'b1; // see R15
            cur_ff      <= data_ff;
            step_cnt_ff <= 13'h0000;
            unit_cnt_ff <= 6'h00;
        end else if (do_end) begin
            state_ff <= ST_IDLE;
            busy_ff  <= 1'b0; // see R16
        end else if (eff_tick && state_ff == ST_PLAY && mode != MODE_NORMAL) begin
            if (step_cnt_ff >= step_last) begin
                step_cnt_ff <= 13'h0000;
                unit_cnt_ff <= unit_cnt_ff + 6'h01;
            end else begin
                step_cnt_ff <= step_cnt_ff + 13'h0001;
            end
        end
    end

    // Status flags: hardware set wins over software clear
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            empty_ff <= EMPTY_RST;
            done_ff  <= 1'b0;
        end else begin
            if (do_load || stop_now) begin
                empty_ff <= 1'b1; // see R15
            end else if (data_wr) begin
                empty_ff <= 1'b0; // see R17
            end
            if (do_end) begin
                done_ff <= 1'b1; // see R16
            end else if (data_wr || (wr_flags && reg_wdata_i[DONE_BIT])) begin
                done_ff <= 1'b0; // see R17
            end
        end
    end

    //--------------------------------------------------------------------------
    // Waveform and pins
    //--------------------------------------------------------------------------
    tone_gen u_tone (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .tick_i    (eff_tick),
        .restart_i (do_load && !(melody && data_ff[TIE_BIT])), // see R14
        .melody_i  (melody),
        .freq_i    (cur_ff[FREQ_LSB +: 8]),
        .duty_i    (cur_ff[LEN_LSB +: 6]),
        .wave_o    (wave)
    );

    // Untied melody note opens with one silent tick
    assign gap      = melody && !cur_ff[TIE_BIT] && (step_cnt_ff == 13'h0000) && (unit_cnt_ff == 6'h00); // see R14
    assign sounding = busy_ff && !(melody && cur_ff[REST_BIT]) && !gap;
    assign nxt_buzz = sounding && wave;

    // Normal drive gives the complement while busy, direct drive holds it low
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            buzz_o   <= 1'b0;
            buzz_n_o <= 1'b0;
        end else begin
            buzz_o   <= nxt_buzz;
            buzz_n_o <= select_ff[DRIVE_BIT] && busy_ff && !nxt_buzz; // see R08
        end
    end

    // Level interrupt from unmasked flags
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |({empty_ff, done_ff} & mask_ff);
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                ADR_CLOCK:  reg_rdata_o <= clock_ctl_ff;
                ADR_SELECT: reg_rdata_o <= select_ff;
                ADR_RUN:    reg_rdata_o <= 16'((32'(stop_ff) << STOP_BIT) | 32'(enable_ff));
                ADR_DATA:   reg_rdata_o <= data_ff;
                ADR_FLAGS:  reg_rdata_o <= 16'((32'(busy_ff) << BUSY_BIT) | (32'(empty_ff) << EMPTY_BIT) | 32'(done_ff));
                ADR_MASK:   reg_rdata_o <= {14'h0000, mask_ff};
                default:    reg_rdata_o <= 16'h0000; // see R19
            endcase
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    //--------------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    // A trigger in the same cycle sets the flags again, and the set wins
    sequence s_data_write;
        data_wr && !eff_tick;
    endsequence

    sequence s_loaded;
        busy_ff && empty_ff && (state_ff == ST_PLAY);
    endsequence

    AST_WRITE_CLEARS_FLAGS: assert property (s_data_write |=> !empty_ff && !done_ff) // see R17
        else $error("data write did not clear flags");
    AST_LOAD_SETS_BUSY: assert property (do_load |=> s_loaded ##0 (cur_ff == $past(data_ff))) // see R15
        else $error("load did not set busy and empty");
    AST_END_SETS_DONE: assert property (do_end |=> !busy_ff && done_ff) // see R16
        else $error("end of output did not raise done");
    AST_BYTE_WRITE_DROPPED: assert property (reg_wr_i && reg_addr_i == ADR_DATA && !reg_wr_full_i
        |=> $stable(data_ff)) // see R18
        else $error("byte write changed sound buffer");
    AST_CLOCK_LOCKED: assert property (reg_wr_i && reg_addr_i == ADR_CLOCK && enable_ff
        |=> $stable(clock_ctl_ff)) // see R04
        else $error("clock register changed while enabled");
    AST_DISABLED_NO_TICK: assert property (!enable_ff |=> !div_tick) // see R12
        else $error("operating tick while disabled");
    AST_DEBUG_HALTS: assert property (debug_mode_i && !clock_ctl_ff[DEBUG_CLOCK_RUN_BIT] |=> !div_tick) // see R01
        else $error("operating tick in debug without run bit");
    AST_STOP_FINISHES: assert property (stop_ff && eff_tick |=> !busy_ff && !stop_ff ##1 !busy_ff) // see R10
        else $error("stop did not end output");
    AST_RESERVED_ZERO: assert property (reg_rd_i && reg_addr_i == ADR_SELECT
        |=> (reg_rdata_o & ~SELECT_MASK) == 16'h0000) // see R19
        else $error("reserved bits read nonzero");
endmodule

/* sound_pkg.sv */
/*
 * Constants, field layout and types of the buzzer and melody sound generator.
 * Assumes one 125 MHz system clock; oscillator sources arrive as one-cycle tick pulses.
 */
//------------------------------------------------------------------------------
// Contract
// R01 - Debug run bit keeps clock in debug
// R02 - Divider codes 0-5 give 1/4 to 1/128
// R03 - Source field picks oscillator; some only undivided
// R04 - Clock settings changed only while disabled
// R05 - Melody tempo 480 divided by code plus one
// R06 - One-shot duration in 1/64 second steps
// R07 - Tempo field untouched while busy; the code accepts select writes at any time
// R08 - Drive bit picks normal or direct drive
// R09 - Mode field: normal, one-shot, melody, reserved
// R10 - Stop write starts stop; reads busy stopping
// R11 - Stop ends normal mode; aborts other modes
// R12 - Enable bit gates the operating clock
// R13 - Data write starts output with fields
// R14 - Tie joins melody note without break
// R15 - Load sets empty and busy flags
// R16 - No new data: stop, done, not busy
// R17 - Done cleared by one or data write
// R18 - Byte writes to data are discarded
// R19 - Reserved bits read zero, writes ignored
//------------------------------------------------------------------------------
package sound_pkg;

    // Register indices on the plain register port
    localparam int          ADDR_W     = 3;
    localparam int          DATA_W     = 16;
    localparam logic [2:0]  ADR_CLOCK  = 3'h0;
    localparam logic [2:0]  ADR_SELECT = 3'h1;
    localparam logic [2:0]  ADR_RUN    = 3'h2;
    localparam logic [2:0]  ADR_DATA   = 3'h3;
    localparam logic [2:0]  ADR_FLAGS  = 3'h4;
    localparam logic [2:0]  ADR_MASK   = 3'h5;

    // Field positions
    localparam int DEBUG_CLOCK_RUN_BIT = 8;
    localparam int DIV_LSB   = 4;
    localparam int SRC_LSB   = 0;
    localparam int STIM_LSB  = 8;
    localparam int DRIVE_BIT = 2;
    localparam int MODE_LSB  = 0;
    localparam int STOP_BIT  = 8;
    localparam int EN_BIT    = 0;
    localparam int TIE_BIT   = 15;
    localparam int REST_BIT  = 14;
    localparam int LEN_LSB   = 8;
    localparam int FREQ_LSB  = 0;
    localparam int BUSY_BIT  = 8;
    localparam int EMPTY_BIT = 1;
    localparam int DONE_BIT  = 0;

    // Writable bits of the clock control and mode select registers
    localparam logic [15:0] CLOCK_MASK  = 16'h0173;
    localparam logic [15:0] SELECT_MASK = 16'h0f07;

    // Reset values
    localparam logic [15:0] DATA_RST  = 16'h00ff;
    localparam logic        EMPTY_RST = 1'h1;

    // Clock sources and divider codes
    localparam logic [1:0] SRC_INTERNAL   = 2'h0;
    localparam logic [1:0] SRC_LOW_SPEED  = 2'h1;
    localparam logic [1:0] SRC_HIGH_SPEED = 2'h2;
    localparam logic [1:0] SRC_EXTERNAL   = 2'h3;
    localparam logic [2:0] DIV_LAST_CODE  = 3'h5;
    localparam logic [2:0] DIV_UNDIVIDED  = 3'h7;
    localparam logic [7:0] DIV_BASE       = 8'h04;

    // Output modes
    localparam logic [1:0] MODE_NORMAL  = 2'h0;
    localparam logic [1:0] MODE_ONESHOT = 2'h1;
    localparam logic [1:0] MODE_MELODY  = 2'h2;

    // Step of tempo and duration: 1/64 s at the nominal operating clock
    localparam int          OP_CLK_HZ    = 32768;
    localparam int          STEPS_PER_S  = 64;
    localparam logic [12:0] STEP_TICKS   = 13'(OP_CLK_HZ / STEPS_PER_S);

    typedef enum logic {ST_IDLE, ST_PLAY} play_state_type;

endpackage

/* op_clock_div.sv */
/*
 * Divider of the selected oscillator tick stream into operating clock ticks.
 * Assumes src_tick_i is already gated by enable and debug state.
 */
`timescale 1ns/1ps
module op_clock_div
    import sound_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    input  wire logic       src_tick_i,
    input  wire logic [2:0] div_code_i,
    input  wire logic       undiv_only_i,
    output logic            op_tick_o
);
    logic [7:0] cnt_ff;
    logic [7:0] ratio_last;
    logic       div_ok;

    // Ratio of the code and whether the source accepts it
    always_comb begin
        ratio_last = 8'((DIV_BASE << div_code_i) - 8'h01);
        if (undiv_only_i) begin
            div_ok = (div_code_i == DIV_UNDIVIDED); // see R03
        end else begin
            div_ok = (div_code_i <= DIV_LAST_CODE); // see R02
        end
    end

    // Tick counter and registered output pulse
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            cnt_ff    <= 8'h00;
            op_tick_o <= 1'b0;
        end else begin
            op_tick_o <= 1'b0;
            if (src_tick_i && div_ok) begin
                if (undiv_only_i || cnt_ff >= ratio_last) begin
                    cnt_ff    <= 8'h00;
                    op_tick_o <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + 8'h01;
                end
            end
        end
    end
endmodule

/* tone_gen.sv */
/*
 * Square wave of the current note or buzzer setting, advanced by operating ticks.
 * Assumes restart_i and tick_i are one-cycle pulses of the system clock.
 */
`timescale 1ns/1ps
module tone_gen (
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    input  wire logic       tick_i,
    input  wire logic       restart_i,
    input  wire logic       melody_i,
    input  wire logic [7:0] freq_i,
    input  wire logic [5:0] duty_i,
    output logic            wave_o
);
    logic [7:0] phase_ff;
    logic [7:0] period_last;

    // Melody uses all scale bits, buzzer only the low six
    assign period_last = melody_i ? freq_i : {2'h0, freq_i[5:0]};

    // Phase counter, one step per operating tick
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            phase_ff <= 8'h00;
        end else if (restart_i) begin
            phase_ff <= 8'h00;
        end else if (tick_i) begin
            phase_ff <= (phase_ff >= period_last) ? 8'h00 : phase_ff + 8'h01;
        end
    end

    // Half period high in melody, duty count high in buzzer modes
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            wave_o <= 1'b0;
        end else if (melody_i) begin
            wave_o <= (phase_ff <= {1'b0, period_last[7:1]});
        end else begin
            wave_o <= (phase_ff < {2'h0, duty_i});
        end
    end
endmodule

/* buzzer_model.sv */
/*
 * Passive buzzer on the two sound output pins.
 * Assumes both pins are registered on clk_i and sampled mid-cycle.
 */
`timescale 1ns/1ps
module buzzer_model (
    input  wire logic clk_i,
    input  wire logic buzz_i,
    input  wire logic buzz_n_i,
    output int        rise_o,
    output int        clash_o,
    output int        inv_high_o
);
    //--------------------------------------------------------------
    // Pin watch
    //--------------------------------------------------------------
    logic last_ff = 1'b0;

    initial begin
        rise_o     = 0;
        clash_o    = 0;
        inv_high_o = 0;
    end

    // Counts tone edges and both pins high at once
    always @(negedge clk_i) begin
        if (buzz_i === 1'b1 && last_ff === 1'b0) begin
            rise_o++;
        end
        if (buzz_i === 1'b1 && buzz_n_i === 1'b1) begin
            clash_o++;
        end
        if (buzz_n_i === 1'b1) begin
            inv_high_o++;
        end
        last_ff = buzz_i;
    end
endmodule

/* sound_generator_tb.sv */
/*
 * Self-checking bench of the sound generator: registers, flags, playback.
 * Assumes the buzzer model file and the design package are compiled first.
 */
`timescale 1ns/1ps
module sound_generator_tb
    import sound_pkg::*;
;
    //--------------------------------------------------------------
    // Signals
    //--------------------------------------------------------------
    logic        clk_sys_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic [2:0]  reg_addr_i = 3'h0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic        reg_wr_i = 1'b0;
    logic        reg_wr_full_i = 1'b1;
    logic        reg_rd_i = 1'b0;
    logic [15:0] reg_rdata_o;
    logic        debug_mode_i = 1'b0;
    logic        buzz_o;
    logic        buzz_n_o;
    logic        irq_o;
    logic        rd_d = 1'b0;
    logic [15:0] exp_q[$];
    logic [15:0] note;
    int          err_total = 0;
    int          comparisons = 0;
    int          rises;
    int          clashes;
    int          cnt;
    int          inv_highs;
    int          r_snap;
    int          n_snap;

    sound_generator DUT (
        .clk_sys_i             (clk_sys_i),
        .resetn_i              (resetn_i),
        .reg_addr_i            (reg_addr_i),
        .reg_wdata_i           (reg_wdata_i),
        .reg_wr_i              (reg_wr_i),
        .reg_wr_full_i         (reg_wr_full_i),
        .reg_rd_i              (reg_rd_i),
        .reg_rdata_o           (reg_rdata_o),
        .debug_mode_i          (debug_mode_i),
        .internal_osc_tick_i   (1'b1),
        .low_speed_osc_tick_i  (1'b1),
        .high_speed_osc_tick_i (1'b0),
        .external_clock_tick_i (1'b0),
        .buzz_o                (buzz_o),
        .buzz_n_o              (buzz_n_o),
        .irq_o                 (irq_o)
    );

    buzzer_model buzzer (
        .clk_i      (clk_sys_i),
        .buzz_i     (buzz_o),
        .buzz_n_i   (buzz_n_o),
        .rise_o     (rises),
        .clash_o    (clashes),
        .inv_high_o (inv_highs)
    );

    //--------------------------------------------------------------
    // Clock, checks and bus tasks
    //--------------------------------------------------------------
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    task automatic summarize();
        if (err_total == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic full = 1'b1);
        @(posedge clk_sys_i);
        reg_addr_i    <= a;
        reg_wdata_i   <= d;
        reg_wr_full_i <= full;
        reg_wr_i      <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i      <= 1'b0;
    endtask

    // Read request; expectation noted for the monitor
    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        @(posedge clk_sys_i);
        exp_q.push_back(e);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i   <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge clk_sys_i) rd_d <= reg_rd_i;
    always @(negedge clk_sys_i) begin
        if (rd_d === 1'b1 && exp_q.size() > 0) begin
            cmp(exp_q.pop_front(), reg_rdata_o);
        end
    end

    initial begin
        #200000;
        err_total++;
        summarize();
    end

    //--------------------------------------------------------------
    // Scenarios
    //--------------------------------------------------------------
    initial begin
        void'($urandom(71480));
        note = {8'h01, 2'h0, 6'(1 + $urandom % 32)};
        idle(5);
        resetn_i <= 1'b1;
        // Reset values and unmapped index
        rd(3'h0, 16'h0000);
        rd(3'h1, 16'h0000);
        rd(3'h2, 16'h0000);
        rd(3'h3, 16'h00ff);
        rd(3'h4, 16'h0002);
        rd(3'h5, 16'h0000);
        rd(3'h6, 16'h0000);
        wr(ADR_CLOCK, 16'hffff);
        rd(ADR_CLOCK, 16'h0173);
        wr(ADR_CLOCK, 16'h0000);
        wr(ADR_SELECT, 16'hffff);
        rd(ADR_SELECT, 16'h0f07);
        wr(ADR_SELECT, 16'h0004);
        wr(ADR_MASK, 16'h0001);
        wr(ADR_RUN, 16'h0001);
        // Clock settings frozen while enabled
        wr(ADR_CLOCK, 16'h0173);
        rd(ADR_CLOCK, 16'h0000);
        rd(ADR_RUN, 16'h0001);
        wr(ADR_DATA, 16'h1234, 1'b0);
        rd(ADR_DATA, 16'h00ff);
        rd(ADR_FLAGS, 16'h0002);
        // Normal buzzer plays until stopped
        wr(ADR_DATA, note);
        rd(ADR_FLAGS, 16'h0000);
        rd(ADR_DATA, note);
        idle(20);
        rd(ADR_FLAGS, 16'h0102);
        idle(600);
        cmp(16'h1, 16'(rises > 0));
        cmp(16'h0, 16'(clashes));
        cmp(16'h1, 16'(inv_highs > 0));
        wr(ADR_RUN, 16'h0101);
        rd(ADR_RUN, 16'h0101);
        idle(20);
        rd(ADR_RUN, 16'h0001);
        rd(ADR_FLAGS, 16'h0003);
        cmp(16'h1, 16'(irq_o));
        wr(ADR_FLAGS, 16'h0001);
        idle(2);
        cmp(16'h0, 16'(irq_o));
        rd(ADR_FLAGS, 16'h0002);
        // One-shot, first held off by debug
        wr(ADR_RUN, 16'h0000);
        wr(ADR_SELECT, 16'h0005);
        wr(ADR_RUN, 16'h0001);
        debug_mode_i <= 1'b1;
        wr(ADR_DATA, note);
        idle(300);
        rd(ADR_FLAGS, 16'h0000);
        @(posedge clk_sys_i);
        debug_mode_i <= 1'b0;
        cnt = 0;
        while (irq_o !== 1'b1 && cnt < 3000) begin
            @(posedge clk_sys_i);
            cnt++;
        end
        cmp(16'h1, 16'(cnt >= 2044 && cnt <= 2064));
        rd(ADR_FLAGS, 16'h0003);
        wr(ADR_DATA, note);
        rd(ADR_FLAGS, 16'h0000);
        idle(4);
        // Tied melody, direct drive, undivided low-speed source running in debug
        wr(ADR_RUN, 16'h0101);
        idle(8);
        wr(ADR_RUN, 16'h0000);
        wr(ADR_CLOCK, 16'h0171);
        wr(ADR_SELECT, 16'h0002);
        wr(ADR_RUN, 16'h0001);
        debug_mode_i <= 1'b1;
        r_snap = rises;
        n_snap = inv_highs;
        wr(ADR_DATA, 16'h0010);
        idle(8);
        wr(ADR_DATA, 16'h8010);
        cnt = 0;
        while (irq_o !== 1'b1 && cnt < 3000) begin
            @(posedge clk_sys_i);
            cnt++;
        end
        cmp(16'h1, 16'(cnt >= 1008 && cnt <= 1028));
        cmp(16'h1, 16'(rises > r_snap));
        cmp(16'(n_snap), 16'(inv_highs));
        rd(ADR_FLAGS, 16'h0003);
        summarize();
    end
endmodule
